/* File: pdc_pkg.sv */
// Package: constants and types for the programmable down counter
package pdc_pkg;

	// ----------------------------------------
	// Bus geometry
	// ----------------------------------------
	localparam int PDC_ADDR_W = 5;
	localparam int PDC_DATA_W = 32;
	localparam int PDC_CNT_W = 8;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [PDC_ADDR_W-1:0] PDC_OFS_CTRL = 5'h00;
	localparam logic [PDC_ADDR_W-1:0] PDC_OFS_PRESET = 5'h04;
	localparam logic [PDC_ADDR_W-1:0] PDC_OFS_COUNT = 5'h08;
	localparam logic [PDC_ADDR_W-1:0] PDC_OFS_STATUS = 5'h0c;
	localparam logic [PDC_ADDR_W-1:0] PDC_OFS_STEP = 5'h10;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int PDC_CTRL_FORCE_MAX_N = 0;
	localparam int PDC_CTRL_ASYNC_LOAD_N = 1;
	localparam int PDC_CTRL_SYNC_LOAD_N = 2;
	localparam int PDC_CTRL_COUNT_ENABLE_N = 3;
	localparam int PDC_CTRL_PIN_CLOCK_EN = 4;
	localparam int PDC_CTRL_W = 5;
	localparam int PDC_STAT_TZ_N = 0;
	localparam int PDC_STAT_BCD = 1;
	localparam int PDC_STAT_EN_PIN_N = 2;
	localparam int PDC_STEP_GO = 0;

	// ----------------------------------------
	// Reset values and counter limits
	// ----------------------------------------
	localparam logic [PDC_CTRL_W-1:0] PDC_CTRL_RESET = 5'h0f;
	localparam logic [PDC_CNT_W-1:0] PDC_PRESET_RESET = 8'h00;
	localparam logic [PDC_CNT_W-1:0] PDC_MAX_BIN = 8'hff;
	localparam logic [PDC_CNT_W-1:0] PDC_MAX_BCD = 8'h99;
	localparam logic [3:0] PDC_DIGIT_MAX = 4'h9;
	localparam logic [PDC_CNT_W-1:0] PDC_ZERO = 8'h00;
	localparam int PDC_SYNC_STAGES = 2;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic count_enable_n;
		logic sync_load_n;
		logic async_load_n;
		logic force_max_n;
	} pdc_ctrl_t;

	typedef enum logic [1:0] {
		PDC_BUS_IDLE,
		PDC_BUS_ACK
	} pdc_bus_t;

endpackage

/* File: pdc_core.sv */
// Counting stage: count register, loads, wrap and terminal-zero flag
module pdc_core
	import pdc_pkg::*;
#(
	parameter bit BCD_MODE = 1'b0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire pdc_ctrl_t ctrl_i,
	input wire logic tick_i,
	input wire logic [PDC_CNT_W-1:0] preset_value_i,
	// State
	output logic [PDC_CNT_W-1:0] count_o,
	output logic terminal_zero_n_o
);

	localparam logic [PDC_CNT_W-1:0] MAX_COUNT = BCD_MODE ? PDC_MAX_BCD : PDC_MAX_BIN;

	logic [PDC_CNT_W-1:0] next_count;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Loads above the variant's ceiling are clipped digit by digit
	function automatic logic [PDC_CNT_W-1:0] fit(input logic [PDC_CNT_W-1:0] v);
		logic [3:0] hi;
		logic [3:0] lo;
		hi = v[7:4];
		lo = v[3:0];
		if (!BCD_MODE) begin
			return v;
		end
		if (hi > PDC_DIGIT_MAX) begin
			hi = PDC_DIGIT_MAX;
		end
		if (lo > PDC_DIGIT_MAX) begin
			lo = PDC_DIGIT_MAX;
		end
		return {hi, lo};
	endfunction

	function automatic logic [PDC_CNT_W-1:0] dec(input logic [PDC_CNT_W-1:0] v);
		if (v == PDC_ZERO) begin
			return MAX_COUNT;
		end
		if (!BCD_MODE) begin
			return v - 8'h01;
		end
		if (v[3:0] == 4'h0) begin
			return {v[7:4] - 4'h1, PDC_DIGIT_MAX};
		end
		return {v[7:4], v[3:0] - 4'h1};
	endfunction

	// ----------------------------------------
	// Next count, by priority
	// ----------------------------------------
	always_comb begin
		next_count = count_o;
		if (!ctrl_i.force_max_n) begin
			next_count = MAX_COUNT;
		end else if (!ctrl_i.async_load_n) begin
			next_count = fit(preset_value_i);
		end else if (tick_i) begin
			if (!ctrl_i.sync_load_n) begin
				next_count = fit(preset_value_i);
			end else if (!ctrl_i.count_enable_n) begin
				next_count = dec(count_o);
			end
		end
	end

	// ----------------------------------------
	// State
	// ----------------------------------------
	// Only tick edges move the count in normal modes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_o <= MAX_COUNT;
		end else begin
			count_o <= next_count;
		end
	end

	// Flag follows the new count so it stays aligned with count_o
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			terminal_zero_n_o <= 1'b1;
		end else begin
			terminal_zero_n_o <= ~(next_count == PDC_ZERO && !ctrl_i.count_enable_n);
		end
	end

endmodule

/* File: pdc_top.sv */
// Programmable down counter with Wishbone register access
//
// Behaviour
// - Eight-stage down counter; count moves only on tick, except clear and async load.
// - Decimal variant holds two BCD digits; largest count or load is 99.
// - Binary variant holds eight binary bits; largest count or load is 255.
// - Clear low forces maximum count at once, overriding all other controls.
// - Async load low copies preset at once, ignoring sync load and enable.
// - Sync load low loads preset on the next count tick, whatever the enable.
// - With loads and clear high and enable low, each tick decrements by one.
// - With enable high and loads and clear high, the count holds.
// - A counting tick at zero wraps to maximum: divide by 100 or 256.
// - Terminal-zero output is low while count is zero and enable is low.
// - While enable is high, terminal-zero output stays high even at zero.
//
// Our own choices: the Wishbone slave port and the register addresses.
module pdc_top
	import pdc_pkg::*;
#(
	parameter bit BCD_MODE = 1'b0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [PDC_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [PDC_DATA_W-1:0] wb_dat_i,
	output logic [PDC_DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// Counter pins
	input wire logic count_clock_i,
	input wire logic count_enable_n_i,
	output logic terminal_zero_n_o,
	output logic [PDC_CNT_W-1:0] count_o
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [PDC_CTRL_W-1:0] ctrl;
	logic [PDC_CNT_W-1:0] preset;
	logic step;
	logic [PDC_SYNC_STAGES-1:0] clk_sync;
	logic [PDC_SYNC_STAGES-1:0] en_sync;
	logic clk_last;
	logic pin_tick;
	logic tick;
	logic wr_go;
	logic rd_go;
	pdc_ctrl_t core_ctrl;
	pdc_bus_t bus_state;

	// Writes land on the edge where the master samples ack, never earlier
	assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign rd_go = wb_cyc_i && wb_stb_i && !wb_we_i && bus_state == PDC_BUS_IDLE;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Pins are foreign to clk_i; only the second stage is used
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_sync <= '0;
			en_sync <= '1;
		end else begin
			clk_sync <= {clk_sync[0], count_clock_i};
			en_sync <= {en_sync[0], count_enable_n_i};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_last <= 1'b0;
		end else begin
			clk_last <= clk_sync[1];
		end
	end

	// Rising edge of the pin clock; pin rate must stay under clk_i / 4
	assign pin_tick = clk_sync[1] && !clk_last && ctrl[PDC_CTRL_PIN_CLOCK_EN];
	assign tick = pin_tick || step;

	// Either enable source high inhibits; pin carries the cascade
	always_comb begin
		core_ctrl.force_max_n = ctrl[PDC_CTRL_FORCE_MAX_N];
		core_ctrl.async_load_n = ctrl[PDC_CTRL_ASYNC_LOAD_N];
		core_ctrl.sync_load_n = ctrl[PDC_CTRL_SYNC_LOAD_N];
		core_ctrl.count_enable_n = ctrl[PDC_CTRL_COUNT_ENABLE_N] | en_sync[1];
	end

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	// Ack one cycle after the request, then one idle cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_state <= PDC_BUS_IDLE;
		end else begin
			case (bus_state)
				PDC_BUS_IDLE: begin
					if (wb_cyc_i && wb_stb_i) begin
						bus_state <= PDC_BUS_ACK;
					end
				end
				PDC_BUS_ACK: begin
					bus_state <= PDC_BUS_IDLE;
				end
				default: begin
					bus_state <= PDC_BUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && bus_state == PDC_BUS_IDLE;
		end
	end

	// ----------------------------------------
	// Writable registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= PDC_CTRL_RESET;
		end else if (wr_go && wb_sel_i[0] && wb_adr_i == PDC_OFS_CTRL) begin
			ctrl <= wb_dat_i[PDC_CTRL_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			preset <= PDC_PRESET_RESET;
		end else if (wr_go && wb_sel_i[0] && wb_adr_i == PDC_OFS_PRESET) begin
			preset <= wb_dat_i[PDC_CNT_W-1:0];
		end
	end

	// Software tick: one cycle pulse per write of a one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			step <= 1'b0;
		end else begin
			step <= wr_go && wb_sel_i[0] && wb_adr_i == PDC_OFS_STEP && wb_dat_i[PDC_STEP_GO];
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Unmapped and write-only addresses read as zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (rd_go) begin
			if (wb_adr_i == PDC_OFS_CTRL) begin
				wb_dat_o <= {{(PDC_DATA_W-PDC_CTRL_W){1'b0}}, ctrl};
			end else if (wb_adr_i == PDC_OFS_PRESET) begin
				wb_dat_o <= {{(PDC_DATA_W-PDC_CNT_W){1'b0}}, preset};
			end else if (wb_adr_i == PDC_OFS_COUNT) begin
				wb_dat_o <= {{(PDC_DATA_W-PDC_CNT_W){1'b0}}, count_o};
			end else if (wb_adr_i == PDC_OFS_STATUS) begin
				wb_dat_o <= {29'h0000_0000, en_sync[1], BCD_MODE, terminal_zero_n_o};
			end else begin
				wb_dat_o <= '0;
			end
		end
	end

	// ----------------------------------------
	// Counting stage
	// ----------------------------------------
	pdc_core #(
		.BCD_MODE(BCD_MODE)
	) u_core (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ctrl_i(core_ctrl),
		.tick_i(tick),
		.preset_value_i(preset),
		.count_o(count_o),
		.terminal_zero_n_o(terminal_zero_n_o)
	);

endmodule

/* File: pdc_monitor.sv */
// Checker on the counter's bus and pin ports
module pdc_monitor
	import pdc_pkg::*;
#(
	parameter bit BCD_MODE = 1'b0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [PDC_DATA_W-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Pins
	input wire logic count_clock_i,
	input wire logic count_enable_n_i,
	input wire logic terminal_zero_n_o,
	input wire logic [PDC_CNT_W-1:0] count_o
);
	localparam logic [PDC_CNT_W-1:0] CNT_MAX = BCD_MODE ? PDC_MAX_BCD : PDC_MAX_BIN;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !$past(wb_ack_o)
		|=> wb_ack_o) else $error("ack missing");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	a_dat_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
		else $error("read data moved");
	a_tz_zero: assert property (!terminal_zero_n_o |-> count_o == PDC_ZERO)
		else $error("zero flag at nonzero count");
	a_tz_inhibit: assert property (count_enable_n_i [*5] |-> terminal_zero_n_o)
		else $error("zero flag while inhibited");
	a_count_range: assert property (count_o <= CNT_MAX
		&& (!BCD_MODE || count_o[3:0] <= PDC_DIGIT_MAX)) else $error("count out of range");
	a_count_hold: assert property ((!wb_cyc_i && !count_clock_i) [*6]
		|-> $stable(count_o)) else $error("count moved without tick");
	cover property (!terminal_zero_n_o);
	cover property ($past(count_o) == PDC_ZERO && count_o == CNT_MAX);
	cover property (wb_ack_o && !wb_we_i);
endmodule

bind pdc_top pdc_monitor #(.BCD_MODE(BCD_MODE)) chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_dat_o, .wb_ack_o, .count_clock_i, .count_enable_n_i, .terminal_zero_n_o,
	.count_o);

/* File: pdc_stage_model.sv */
// Earlier cascade stage: count clock bursts and carry level
module pdc_stage_model (
	// Clock and command
	input wire logic clk_i,
	input wire logic inhibit_i,
	// Toward the counter
	output logic count_clock_o,
	output logic enable_n_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial count_clock_o = 1'b0;
	assign enable_n_o = inhibit_i;
	// Slow pulses: the pin is sampled, so stay well under a quarter of clk_i
	task automatic burst(input int n);
		repeat (n) begin
			repeat (4) @(posedge clk_i);
			count_clock_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			count_clock_o <= 1'b0;
		end
	endtask
endmodule

/* File: pdc_top_bench.sv */
// Self-checking bench for the programmable down counter
module pdc_top_bench
	import pdc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, inh = 1'b1, ack, tz_n, pclk, pen_n;
	logic [4:0] adr = '0;
	logic [3:0] sel = '0;
	logic [31:0] wdat = '0, rdat;
	logic [7:0] cnt, r;
	logic [31:0] expq[$];
	logic [32:0] dexpq[$];
	logic [31:0] ddat, exp_bin;
	logic [32:0] exp_dec;
	logic [7:0] dcnt;
	int err_count = 0, cmp_count = 0;
	pdc_top #(.BCD_MODE(1'b0)) uut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.count_clock_i(pclk), .count_enable_n_i(pen_n), .terminal_zero_n_o(tz_n), .count_o(cnt));
	// Decimal variant on the same bus and pins
	pdc_top #(.BCD_MODE(1'b1)) uut_dec (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(ddat),
		.wb_ack_o(), .count_clock_i(pclk), .count_enable_n_i(pen_n), .terminal_zero_n_o(),
		.count_o(dcnt));
	pdc_stage_model part (.clk_i, .inhibit_i(inh), .count_clock_o(pclk), .enable_n_o(pen_n));
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic check(input logic [31:0] seen, exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) check(1'b0, 1'b1, "ack");
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		expq.push_back(e);
		dexpq.push_back({1'b0, 32'h0000_0000});
		bus(1'b0, a, '0, 4'hf);
	endtask
	task automatic rd2(input logic [4:0] a, input logic [31:0] e, input logic [31:0] de);
		expq.push_back(e);
		dexpq.push_back({1'b1, de});
		bus(1'b0, a, '0, 4'hf);
	endtask
	// Results are compared when the read is acknowledged
	always @(posedge clk_i) begin
		if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) begin
			exp_bin = expq.pop_front();
			exp_dec = dexpq.pop_front();
			check(rdat, exp_bin, "read");
			if (adr == PDC_OFS_COUNT) check(32'(cnt), exp_bin, "count pin");
			if (adr == PDC_OFS_STATUS) check(32'(tz_n), 32'(exp_bin[PDC_STAT_TZ_N]), "zero pin");
			if (exp_dec[32]) begin
				check(ddat, exp_dec[31:0], "decimal read");
				if (adr == PDC_OFS_COUNT) check(32'(dcnt), exp_dec[31:0], "decimal pin");
			end
		end
	end
	initial begin
		#200us;
		err_count++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'he441_7a6c));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd2(PDC_OFS_COUNT, 32'h0000_00ff, 32'h0000_0099);
		rd(PDC_OFS_CTRL, 32'h0000_000f);
		rd2(PDC_OFS_STATUS, 32'h0000_0005, 32'h0000_0007);
		$display("reset test done");
		r = 8'($urandom_range(255, 2));
		wr(PDC_OFS_PRESET, {24'h00_0000, r});
		wr(PDC_OFS_CTRL, 32'h0000_000d);
		wr(PDC_OFS_CTRL, 32'h0000_000f);
		wr(PDC_OFS_STEP, 32'h0000_0001);
		rd(PDC_OFS_COUNT, {24'h00_0000, r});
		inh <= 1'b0;
		wr(PDC_OFS_CTRL, 32'h0000_0007);
		repeat (r) wr(PDC_OFS_STEP, 32'h0000_0001);
		rd(PDC_OFS_COUNT, 32'h0000_0000);
		rd(PDC_OFS_STATUS, 32'h0000_0000);
		wr(PDC_OFS_CTRL, 32'h0000_000f);
		rd(PDC_OFS_STATUS, 32'h0000_0001);
		wr(PDC_OFS_CTRL, 32'h0000_0007);
		inh <= 1'b1;
		repeat (4) @(posedge clk_i);
		rd(PDC_OFS_STATUS, 32'h0000_0005);
		inh <= 1'b0;
		repeat (4) @(posedge clk_i);
		wr(PDC_OFS_STEP, 32'h0000_0001);
		rd(PDC_OFS_COUNT, 32'h0000_00ff);
		$display("count test done");
		r = 8'($urandom_range(255, 0));
		wr(PDC_OFS_PRESET, {24'h00_0000, r});
		wr(PDC_OFS_CTRL, 32'h0000_000b);
		wr(PDC_OFS_STEP, 32'h0000_0001);
		rd(PDC_OFS_COUNT, {24'h00_0000, r});
		wr(PDC_OFS_CTRL, 32'h0000_000e);
		wr(PDC_OFS_STEP, 32'h0000_0001);
		rd2(PDC_OFS_COUNT, 32'h0000_00ff, 32'h0000_0099);
		$display("load test done");
		wr(PDC_OFS_CTRL, 32'h0000_0017);
		part.burst(5);
		repeat (8) @(posedge clk_i);
		rd(PDC_OFS_COUNT, 32'h0000_00fa);
		inh <= 1'b1;
		part.burst(3);
		repeat (8) @(posedge clk_i);
		rd(PDC_OFS_COUNT, 32'h0000_00fa);
		$display("pin test done");
		rd(5'h14, 32'h0000_0000);
		wr(PDC_OFS_COUNT, 32'h0000_0055);
		bus(1'b1, PDC_OFS_CTRL, 32'h0000_000e, 4'h0);
		rd(PDC_OFS_COUNT, 32'h0000_00fa);
		rd(PDC_OFS_CTRL, 32'h0000_0017);
		$display("bus test done");
		inh <= 1'b0;
		wr(PDC_OFS_PRESET, 32'h0000_0010);
		wr(PDC_OFS_CTRL, 32'h0000_000d);
		wr(PDC_OFS_CTRL, 32'h0000_0007);
		wr(PDC_OFS_STEP, 32'h0000_0001);
		rd2(PDC_OFS_COUNT, 32'h0000_000f, 32'h0000_0009);
		repeat (9) wr(PDC_OFS_STEP, 32'h0000_0001);
		rd2(PDC_OFS_COUNT, 32'h0000_0006, 32'h0000_0000);
		rd2(PDC_OFS_STATUS, 32'h0000_0001, 32'h0000_0002);
		wr(PDC_OFS_STEP, 32'h0000_0001);
		rd2(PDC_OFS_COUNT, 32'h0000_0005, 32'h0000_0099);
		$display("decimal test done");
		wrap_up();
	end
endmodule
